// ===== common/scfg_pkg.sv
// register map, field layout and carrier types of the channel config block
package scfg_pkg;
    localparam logic [7:0] IDX_MODE = 8'h10;
    localparam logic [7:0] IDX_TX_DATA = 8'h11;
    localparam logic [7:0] IDX_COMMAND = 8'h12;
    localparam logic [7:0] IDX_STATUS = 8'h13;
    localparam logic [7:0] IDX_FLOW_CHAR = 8'h14;
    localparam logic [7:0] IDX_CCR3L = 8'h1C;
    localparam logic [7:0] IDX_CCR3H = 8'h1D;
    localparam logic [7:0] IDX_LEAD_IN = 8'h1E;
    localparam logic [7:0] IDX_IDLE_TO = 8'h1F;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] FLOW_CHAR_RESET = 16'h1311;
    localparam int B_CSF = 5;
    localparam int B_ERRORED_UNIT_THRESHOLD = 4;
    localparam int B_RAC = 3;
    localparam int B_SS7_ENABLE = 0;
    localparam int B_CHL = 4;
    localparam int B_DXS = 2;
    localparam int B_TX_BREAK_FORCE = 1;
    localparam int B_STOP = 0;
    localparam int B_RX_CHECKSUM_DISABLE = 6;
    localparam int B_RX_CHECKSUM_FORWARD = 5;
    localparam int B_RX_ADDR_FORWARD = 4;
    localparam int B_PAR = 6;
    localparam int B_CHECK_BIT_ENABLE = 5;
    localparam int B_DPS = 4;
    localparam int B_RX_FIFO_STATUS_FORMAT = 3;
    localparam int B_RX_FIFO_THRESHOLD = 0;
    localparam int B_TIMEOUT_AUTO_ENABLE = 7;
    localparam int B_PROTO = 0;
    localparam int B_SUBMODE = 2;
    localparam int B_ADDR_W = 4;
    localparam int B_LEAD_EN = 5;
    localparam int B_LEAD_IN_REPEAT_COUNT = 6;
    localparam int B_TX_RESET = 0;
    localparam int B_FORCE_REL = 1;
    localparam int B_ERR_HIGH = 0;
    localparam logic [1:0] ADDR_MODE0 = 2'h2;
    localparam logic [6:0] ERR_THR_LOW = 7'h40;
    localparam logic [6:0] ERR_THR_HIGH = 7'h20;
    localparam logic [14:0] TO_CHARS_PER_STEP = 15'h0004;
    typedef enum logic [1:0] {
        MODE_ASYNC = 2'h0, MODE_HDLC = 2'h1, MODE_BISYNC = 2'h2
    } proto_type;
    typedef enum logic [3:0] {
        TX_IDLE = 4'h1, TX_DATA = 4'h2, TX_PARITY = 4'h4, TX_STOP = 4'h8
    } tx_state_type;
    typedef enum logic [3:0] {
        RX_IDLE = 4'h1, RX_DATA = 4'h2, RX_PARITY = 4'h4, RX_STOP = 4'h8
    } rx_state_type;
    typedef struct packed {
        logic valid;
        logic is_status;
        logic block_end;
        logic [7:0] data;
    } rx_word_type;
    typedef struct packed {
        logic addr;
        logic fsn_bsn;
        logic checksum;
        logic payload;
    } rx_field_type;
endpackage

// ===== rtl/serial_channel_format_config.sv
// serial channel format, receive filter and transmit control logic
// Notes on behaviour
// - with compare on, repeated LSSUs with equal status are dropped
// - error-rate-high rises when errored units reach 64, or 32
// - length code 00..11 selects eight, seven, six or five data bits
// - receiver off means the receive line is ignored entirely
// - async flow characters are dropped when discard is set
// - break drives transmit low at next transmit clock rise, aborts char
// - pending data waits out a break; transmit reset keeps break
// - SS7 runs in HDLC with enable set, address mode 0, narrow address
// - one stop bit when select clear, two when set
// - parity enable with format zero, odd, even or one
// - parity sits above short data, or in status LSB for 8 bits
// - parity error flagged in status bit 7
// - checksum expected only while receive checking is on
// - checksum always evaluated, forwarded only with forward bit
// - address or FSN/BSN forwarded only with address forward bit
// - parity kept out of data byte when suppressed, always in status
// - status format adds a status byte with parity and framing errors
// - HDLC pool-full at 32,16,4,2 bytes; frame end notifies at once
// - async pool-full at 1,4,16,32 bytes or 1,2,8,16 pairs
// - lead-in pattern is sent without zero insertion
// - auto timeout inserts a block end marker and signals the event
// - timeout after (length+1)*4 quiet character frames
// - lead-in repeats 1, 2, 4 or 8 times
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
module serial_channel_format_config
    import scfg_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic txclk_pin,
    input wire logic rxclk_pin,
    input wire logic rxd_pin,
    output logic txd,
    input wire logic sync_txd,
    input wire logic frame_ready,
    output logic lead_in_active,
    output rx_word_type rx_word,
    input wire logic [6:0] rx_fifo_level,
    input wire logic frame_end,
    output logic rx_pool_full_irq,
    output logic timeout_event,
    input wire logic su_done,
    input wire logic su_is_lssu,
    input wire logic [7:0] su_status,
    input wire logic su_errored,
    output logic lssu_store,
    output logic ss7_active,
    input wire rx_field_type rx_field,
    output logic field_forward,
    output logic checksum_expected
);
    if (ADDR_W < 10) begin : g_bad_width
        $error("ADDR_W must be at least 10");
    end

    function automatic logic [3:0] char_bits(input logic [1:0] code);
        char_bits = 4'h8 - {2'h0, code};
    endfunction

    function automatic logic [7:0] char_mask(input logic [3:0] n);
        char_mask = 8'hFF >> (4'h8 - n);
    endfunction

    function automatic logic parity_of(input logic [7:0] d,
                                       input logic [1:0] fmt);
        unique case (fmt)
            2'h0: parity_of = 1'b0;
            2'h1: parity_of = ~^d;
            2'h2: parity_of = ^d;
            2'h3: parity_of = 1'b1;
        endcase
    endfunction

    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = idx inside {IDX_MODE, IDX_TX_DATA, IDX_COMMAND,
            IDX_STATUS, IDX_FLOW_CHAR, IDX_CCR3L, IDX_CCR3H,
            IDX_LEAD_IN, IDX_IDLE_TO};
    endfunction

    logic [7:0] ccr3l, ccr3h, lead_in, idle_to, mode_reg, tx_hold;
    logic [15:0] flow_char;
    logic [7:0] idx;
    logic wr, tx_reset, force_rel, err_clr;
    logic [1:0] txclk_sync, rxclk_sync, rxd_sync;
    logic txclk_q, rxclk_q, tx_rise, rx_rise, rxd_s;
    proto_type proto;
    logic async_m, hdlc_m, brk, rx_on, check_bit_enable;
    logic [3:0] n_bits;
    logic [7:0] mask;

    assign idx = paddr[9:2];
    assign wr = psel & penable & pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~is_mapped(idx);
    assign tx_reset = wr & (idx == IDX_COMMAND) & pwdata[B_TX_RESET];
    assign force_rel = wr & (idx == IDX_COMMAND) & pwdata[B_FORCE_REL];
    assign err_clr = wr & (idx == IDX_STATUS) & pwdata[B_ERR_HIGH];
    assign proto = proto_type'(mode_reg[B_PROTO +: 2]);
    assign async_m = proto == MODE_ASYNC;
    assign hdlc_m = proto == MODE_HDLC;
    assign brk = async_m & ccr3l[B_TX_BREAK_FORCE];
    assign rx_on = ccr3l[B_RAC];
    assign check_bit_enable = ~hdlc_m & ccr3h[B_CHECK_BIT_ENABLE];
    assign n_bits = char_bits(ccr3l[B_CHL +: 2]);
    assign mask = char_mask(n_bits);

    // register writes take effect only in the access phase
    always_ff @(posedge clk) begin
        if (rst) begin
            ccr3l <= REG_RESET;
            ccr3h <= REG_RESET;
            lead_in <= REG_RESET;
            idle_to <= REG_RESET;
            mode_reg <= REG_RESET;
            tx_hold <= REG_RESET;
            flow_char <= FLOW_CHAR_RESET;
        end else if (wr) begin
            unique case (idx)
                IDX_CCR3L: ccr3l <= pwdata[7:0];
                IDX_CCR3H: ccr3h <= pwdata[7:0];
                IDX_LEAD_IN: lead_in <= pwdata[7:0];
                IDX_IDLE_TO: idle_to <= pwdata[7:0];
                IDX_MODE: mode_reg <= pwdata[7:0];
                IDX_TX_DATA: tx_hold <= pwdata[7:0];
                IDX_FLOW_CHAR: flow_char <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    logic tx_pending, err_high;
    logic [6:0] err_count;
    tx_state_type tx_state;

    // read data sampled in setup so it stands through the access phase
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable) begin
            unique case (idx)
                IDX_CCR3L: prdata <= {24'h0, ccr3l};
                IDX_CCR3H: prdata <= {24'h0, ccr3h};
                IDX_LEAD_IN: prdata <= {24'h0, lead_in};
                IDX_IDLE_TO: prdata <= {24'h0, idle_to};
                IDX_MODE: prdata <= {24'h0, mode_reg};
                IDX_TX_DATA: prdata <= {24'h0, tx_hold};
                IDX_FLOW_CHAR: prdata <= {16'h0, flow_char};
                IDX_STATUS: prdata <= {17'h0, err_count, 4'h0,
                    tx_pending, brk, tx_state != TX_IDLE, err_high};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // pin inputs: two flops, then edge detect on the second stage only
    always_ff @(posedge clk) begin
        if (rst) begin
            txclk_sync <= 2'h0;
            rxclk_sync <= 2'h0;
            rxd_sync <= 2'h3;
            txclk_q <= 1'b0;
            rxclk_q <= 1'b0;
        end else begin
            txclk_sync <= {txclk_sync[0], txclk_pin};
            rxclk_sync <= {rxclk_sync[0], rxclk_pin};
            rxd_sync <= {rxd_sync[0], rxd_pin};
            txclk_q <= txclk_sync[1];
            rxclk_q <= rxclk_sync[1];
        end
    end
    assign tx_rise = txclk_sync[1] & ~txclk_q;
    assign rx_rise = rxclk_sync[1] & ~rxclk_q;
    assign rxd_s = rxd_sync[1];

    logic txd_uart, tx_par;
    logic [7:0] tx_shift;
    logic [3:0] tx_cnt;

    // data written while a break stands just waits in the holding byte
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_pending <= 1'b0;
        end else begin
            if ((tx_rise & ~brk & async_m & tx_state == TX_IDLE) | tx_reset)
                tx_pending <= 1'b0;
            if (wr & idx == IDX_TX_DATA)
                tx_pending <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst | tx_reset) begin
            tx_state <= TX_IDLE;
            txd_uart <= ~brk;
            tx_shift <= 8'h00;
            tx_cnt <= 4'h0;
            tx_par <= 1'b0;
        end else if (tx_rise & brk) begin
            tx_state <= TX_IDLE;
            txd_uart <= 1'b0;
        end else if (tx_rise) begin
            unique case (tx_state)
                TX_IDLE: begin
                    txd_uart <= 1'b1;
                    if (tx_pending & async_m) begin
                        tx_state <= TX_DATA;
                        txd_uart <= 1'b0;
                        tx_shift <= tx_hold & mask;
                        tx_par <= parity_of(tx_hold & mask,
                                            ccr3h[B_PAR +: 2]);
                        tx_cnt <= 4'h0;
                    end
                end
                TX_DATA: begin
                    txd_uart <= tx_shift[0];
                    tx_shift <= tx_shift >> 1;
                    tx_cnt <= tx_cnt + 4'h1;
                    if (tx_cnt == n_bits - 4'h1) begin
                        tx_state <= check_bit_enable ? TX_PARITY : TX_STOP;
                        tx_cnt <= 4'h0;
                    end
                end
                TX_PARITY: begin
                    txd_uart <= tx_par;
                    tx_state <= TX_STOP;
                end
                TX_STOP: begin
                    txd_uart <= 1'b1;
                    tx_cnt <= tx_cnt + 4'h1;
                    if (tx_cnt == {3'h0, ccr3l[B_STOP]})
                        tx_state <= TX_IDLE;
                end
            endcase
        end
    end

    logic [2:0] lead_idx, lead_rep, lead_last;
    assign lead_last = 3'((4'h1 << mode_reg[B_LEAD_IN_REPEAT_COUNT +: 2]) - 4'h1);

    always_ff @(posedge clk) begin
        if (rst) begin
            lead_in_active <= 1'b0;
            lead_idx <= 3'h0;
            lead_rep <= 3'h0;
        end else if (~lead_in_active) begin
            if (frame_ready & ~async_m & mode_reg[B_LEAD_EN]) begin
                lead_in_active <= 1'b1;
                lead_idx <= 3'h0;
                lead_rep <= 3'h0;
            end
        end else if (tx_rise) begin
            lead_idx <= lead_idx + 3'h1;
            if (lead_idx == 3'h7) begin
                lead_rep <= lead_rep + 3'h1;
                if (lead_rep == lead_last)
                    lead_in_active <= 1'b0;
            end
        end
    end

    // lead-in bits bypass the stuffing engine, so no zeros get inserted
    always_ff @(posedge clk) begin
        if (rst)
            txd <= 1'b1;
        else if (async_m)
            txd <= txd_uart;
        else if (lead_in_active)
            txd <= lead_in[lead_idx];
        else
            txd <= sync_txd;
    end

    rx_state_type rx_state;
    logic [7:0] rx_shift, rx_data, rx_status, rx_char, status_hold;
    logic [3:0] rx_cnt;
    logic rx_par, rx_stop_hit, rx_pe, rx_drop, status_pend, release_pend;

    always_ff @(posedge clk) begin
        if (rst | ~rx_on | ~async_m) begin
            rx_state <= RX_IDLE;
            rx_shift <= 8'h00;
            rx_cnt <= 4'h0;
            rx_par <= 1'b0;
        end else if (rx_rise) begin
            unique case (rx_state)
                RX_IDLE: begin
                    if (~rxd_s) begin
                        rx_state <= RX_DATA;
                        rx_cnt <= 4'h0;
                    end
                end
                RX_DATA: begin
                    rx_shift <= {rxd_s, rx_shift[7:1]};
                    rx_cnt <= rx_cnt + 4'h1;
                    if (rx_cnt == n_bits - 4'h1)
                        rx_state <= check_bit_enable ? RX_PARITY : RX_STOP;
                end
                RX_PARITY: begin
                    rx_par <= rxd_s;
                    rx_state <= RX_STOP;
                end
                RX_STOP: rx_state <= RX_IDLE;
            endcase
        end
    end

    assign rx_stop_hit = rx_rise & rx_on & (rx_state == RX_STOP);
    assign rx_char = (rx_shift >> (4'h8 - n_bits)) & mask;
    assign rx_pe = check_bit_enable & (rx_par != parity_of(rx_char, ccr3h[B_PAR +: 2]));
    assign rx_data = rx_char | ((check_bit_enable & ~ccr3h[B_DPS] & n_bits != 4'h8)
        ? ({7'h00, rx_par} << n_bits) : 8'h00);
    assign rx_status = {rx_pe, ~rxd_s, 5'h00,
        check_bit_enable & rx_par};
    assign rx_drop = ccr3l[B_DXS] & (rx_char == (flow_char[7:0] & mask)
        | rx_char == (flow_char[15:8] & mask));

    logic [14:0] to_count, to_units, to_limit;
    logic [4:0] cfl;
    logic to_armed, to_hit;
    assign cfl = {1'b0, n_bits} + 5'h1 + {4'h0, check_bit_enable}
        + (ccr3l[B_STOP] ? 5'h2 : 5'h1);
    assign to_units = {8'h00, idle_to[6:0]} + 15'h0001;
    assign to_limit = 15'(to_units * TO_CHARS_PER_STEP
        * {10'h000, cfl});
    assign to_hit = rx_rise & to_armed & (to_count + 15'h1 == to_limit);

    always_ff @(posedge clk) begin
        if (rst | ~rx_on | ~async_m | ~idle_to[B_TIMEOUT_AUTO_ENABLE]) begin
            to_count <= 15'h0000;
            to_armed <= 1'b0;
            timeout_event <= 1'b0;
        end else begin
            timeout_event <= to_hit;
            if (~rxd_s | rx_state != RX_IDLE) begin
                to_count <= 15'h0000;
                to_armed <= 1'b1;
            end else if (to_hit) begin
                to_armed <= 1'b0;
            end else if (rx_rise & to_armed) begin
                to_count <= to_count + 15'h1;
            end
        end
    end

    // one word per cycle; a status byte or marker waits its turn
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_word <= '0;
            status_pend <= 1'b0;
            status_hold <= 8'h00;
            release_pend <= 1'b0;
        end else begin
            rx_word <= '0;
            if (timeout_event | force_rel)
                release_pend <= 1'b1;
            if (rx_stop_hit & ~rx_drop) begin
                rx_word <= '{1'b1, 1'b0, 1'b0, rx_data};
                status_pend <= ccr3h[B_RX_FIFO_STATUS_FORMAT];
                status_hold <= rx_status;
            end else if (status_pend) begin
                rx_word <= '{1'b1, 1'b1, 1'b0, status_hold};
                status_pend <= 1'b0;
            end else if (release_pend) begin
                rx_word <= '{1'b1, 1'b0, 1'b1, 8'h00};
                release_pend <= timeout_event | force_rel;
            end
        end
    end

    logic [6:0] pool_thr;
    logic pool_over, pool_over_q;
    always_comb begin
        pool_thr = 7'h01;
        if (hdlc_m)
            unique case (ccr3h[B_RX_FIFO_THRESHOLD +: 2])
                2'h0: pool_thr = 7'h20;
                2'h1: pool_thr = 7'h10;
                2'h2: pool_thr = 7'h04;
                2'h3: pool_thr = 7'h02;
            endcase
        else
            unique case (ccr3h[B_RX_FIFO_THRESHOLD +: 2])
                2'h0: pool_thr = ccr3h[B_RX_FIFO_STATUS_FORMAT] ? 7'h02 : 7'h01;
                2'h1: pool_thr = 7'h04;
                2'h2: pool_thr = 7'h10;
                2'h3: pool_thr = 7'h20;
            endcase
    end
    assign pool_over = rx_fifo_level >= pool_thr;

    always_ff @(posedge clk) begin
        if (rst) begin
            pool_over_q <= 1'b0;
            rx_pool_full_irq <= 1'b0;
        end else begin
            pool_over_q <= pool_over;
            rx_pool_full_irq <= (pool_over & ~pool_over_q) | frame_end
                | (rx_word.valid & rx_word.block_end);
        end
    end

    logic last_lssu;
    logic [7:0] last_status;
    logic [6:0] err_thr;
    assign ss7_active = hdlc_m & ccr3l[B_SS7_ENABLE] & ~mode_reg[B_ADDR_W]
        & (mode_reg[B_SUBMODE +: 2] == ADDR_MODE0);
    assign err_thr = ccr3l[B_ERRORED_UNIT_THRESHOLD] ? ERR_THR_HIGH : ERR_THR_LOW;

    always_ff @(posedge clk) begin
        if (rst) begin
            lssu_store <= 1'b0;
            last_lssu <= 1'b0;
            last_status <= 8'h00;
        end else begin
            lssu_store <= 1'b0;
            if (su_done & ss7_active) begin
                last_lssu <= su_is_lssu;
                last_status <= su_status;
                lssu_store <= su_is_lssu & ~(ccr3l[B_CSF] & last_lssu
                    & su_status == last_status);
            end
        end
    end

    // the count freezes at the threshold until software clears the flag
    always_ff @(posedge clk) begin
        if (rst) begin
            err_count <= 7'h00;
            err_high <= 1'b0;
        end else begin
            if (err_clr) begin
                err_count <= 7'h00;
                err_high <= 1'b0;
            end
            if (su_errored & ss7_active & ~err_high) begin
                err_count <= err_count + 7'h01;
                if (err_count + 7'h01 >= err_thr)
                    err_high <= 1'b1;
            end
        end
    end

    assign checksum_expected = hdlc_m & ~ccr3h[B_RX_CHECKSUM_DISABLE];
    assign field_forward = hdlc_m & (rx_field.payload
        | (rx_field.checksum & checksum_expected
           & ccr3h[B_RX_CHECKSUM_FORWARD])
        | (rx_field.addr & ccr3h[B_RX_ADDR_FORWARD]
           & mode_reg[B_SUBMODE +: 2] != ADDR_MODE0)
        | (rx_field.fsn_bsn & ccr3h[B_RX_ADDR_FORWARD] & ss7_active));

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    chk_break_drives_low: assert property (
        tx_rise && brk && !tx_reset |=> ##1 txd == 1'b0)
        else $error("break did not force transmit low");
    chk_break_survives_reset: assert property (
        brk && tx_reset |=> brk && tx_state == TX_IDLE)
        else $error("transmit reset cleared the break");
    chk_rx_off_silent: assert property (
        !rx_on ##1 !rx_on |=> !(rx_word.valid && !rx_word.block_end))
        else $error("receiver off yet a character was stored");
    chk_err_rate_flag: assert property (
        su_errored && ss7_active && !err_high && !err_clr
        && err_count == err_thr - 7'h01 |=> err_high)
        else $error("error rate flag missed its threshold");
    chk_lssu_repeat_drop: assert property (
        su_done && ss7_active && su_is_lssu && ccr3l[B_CSF] && last_lssu
        && su_status == last_status |=> !lssu_store)
        else $error("repeated LSSU was stored");
    chk_frame_end_notify: assert property (
        frame_end |=> rx_pool_full_irq)
        else $error("frame end did not notify at once");
    chk_lead_in_bits: assert property (
        lead_in_active && !async_m |=> txd == $past(lead_in[lead_idx]))
        else $error("lead-in pattern bit altered on the line");
    chk_timeout_marker: assert property (
        timeout_event |-> ##[1:3] (rx_word.valid && rx_word.block_end))
        else $error("timeout gave no block end marker");
    chk_status_follows: assert property (
        rx_word.valid && !rx_word.is_status && !rx_word.block_end
        && ccr3h[B_RX_FIFO_STATUS_FORMAT] |=> rx_word.valid && rx_word.is_status)
        else $error("status byte did not follow its character");

    cover property (tx_rise && brk && tx_state != TX_IDLE);
    cover property (rx_word.valid && rx_word.is_status && rx_word.data[7]);
    cover property (!err_high ##1 err_high);
    cover property (timeout_event);
endmodule

// ===== testbench/remote_station.sv
// far-side serial station: bit clocks and receive line
`timescale 1ns/10ps
module remote_station (
    input wire logic tx_run,
    input wire logic go,
    input wire logic [7:0] ch,
    input wire logic [7:0] tail,
    output logic txclk,
    output logic rxclk,
    output logic rxd
);
    initial begin
        txclk = 1'b0;
        rxclk = 1'b0;
        rxd = 1'b1;
    end
    // transmit clock only while the bench asks for it
    always begin
        #62.5;
        txclk = tx_run ? ~txclk : 1'b0;
    end
    // start, eight data bits lsb first, one stop, then tail mark bits
    // with the clock still running, as a free receive clock would
    always @(posedge go) begin : frame
        for (int i = 0; i < 10 + tail; i++) begin
            rxd = (i == 0) ? 1'b0 : (i >= 9) ? 1'b1 : ch[i-1];
            #62.5 rxclk = 1'b1;
            #62.5 rxclk = 1'b0;
        end
    end
endmodule

// ===== testbench/serial_channel_format_config_tb.sv
// self-checking bench: registers over apb, receive and break
`timescale 1ns/10ps
module serial_channel_format_config_tb;
    import scfg_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, txd, e;
    logic tx_run, go, txclk, rxclk, rxd, frame_ready, frame_end;
    logic su_done, su_is_lssu, su_errored, sync_txd;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] su_status;
    logic [6:0] rx_fifo_level;
    logic [7:0] tail;
    rx_word_type rx_word;
    rx_field_type rx_field;
    int err_total, samples_checked;
    logic [7:0] ridx [4] = '{IDX_CCR3L, IDX_CCR3H, IDX_LEAD_IN, IDX_IDLE_TO};
    logic [7:0] wv [4] = '{8'h38, 8'h7B, 8'hA5, 8'h85};
    serial_channel_format_config dut_u (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .txclk_pin(txclk), .rxclk_pin(rxclk), .rxd_pin(rxd), .txd(txd),
        .sync_txd(sync_txd), .frame_ready(frame_ready), .lead_in_active(),
        .rx_word(rx_word), .rx_fifo_level(rx_fifo_level),
        .frame_end(frame_end), .rx_pool_full_irq(), .timeout_event(),
        .su_done(su_done), .su_is_lssu(su_is_lssu), .su_status(su_status),
        .su_errored(su_errored), .lssu_store(), .ss7_active(),
        .rx_field(rx_field), .field_forward(), .checksum_expected());
    remote_station peer_u (.tx_run(tx_run), .go(go), .ch(8'hA5), .tail(tail),
        .txclk(txclk), .rxclk(rxclk), .rxd(rxd));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task summarize;
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        samples_checked++;
        if (s !== x) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, x, s);
        end
    endtask
    // one apb transfer; waits on pready rather than assuming zero wait
    task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            err_total++;
            summarize();
        end
    endtask
    // waits on negedges for a received word, block end marker or not
    task wait_word(input logic be);
        int n;
        n = 0;
        while (!(rx_word.valid === 1'b1 && rx_word.block_end === be)
               && n < 4000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 4000) begin
            err_total++;
            summarize();
        end
    endtask
    initial begin
        {psel, penable, pwrite, tx_run, go, frame_ready, frame_end} = '0;
        {su_done, su_is_lssu, su_errored, sync_txd} = '0;
        {paddr, pwdata, su_status, rx_fifo_level, rx_field, tail} = '0;
        err_total = 0;
        samples_checked = 0;
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, ridx[i], 32'h0);
            chk("reset value", q, 32'h0);
            apb(1'b1, ridx[i], {24'h0, wv[i]});
            apb(1'b0, ridx[i], 32'h0);
            chk("read back", q, {24'h0, wv[i]});
        end
        apb(1'b0, 8'h3F, 32'h0);
        chk("unmapped error", {31'h0, e}, 32'h1);
        // receiver on, 8 bits, status bytes, no parity
        apb(1'b1, IDX_CCR3L, 32'h08);
        apb(1'b1, IDX_CCR3H, 32'h08);
        @(posedge clk) go <= 1'b1;
        @(posedge clk) go <= 1'b0;
        wait_word(1'b0);
        chk("rx data", {21'h0, rx_word}, {21'h0, 3'b100, 8'hA5});
        @(negedge clk);
        chk("rx status", {21'h0, rx_word}, {21'h0, 3'b110, 8'h00});
        // break, then a transmit reset and a pending byte under it
        apb(1'b1, IDX_CCR3L, 32'h0A);
        tx_run <= 1'b1;
        repeat (80) @(negedge clk);
        chk("break level", {31'h0, txd}, 32'h0);
        apb(1'b1, IDX_COMMAND, 32'h01);
        apb(1'b1, IDX_TX_DATA, 32'h55);
        repeat (120) @(negedge clk);
        chk("break kept", {31'h0, txd}, 32'h0);
        apb(1'b0, IDX_STATUS, 32'h0);
        chk("break flag", {28'h0, q[3:0]}, 32'h0000_000C);
        // clearing the break lets the held byte go out
        apb(1'b1, IDX_CCR3L, 32'h08);
        repeat (60) @(negedge clk);
        apb(1'b0, IDX_STATUS, 32'h0);
        chk("sent after break", {28'h0, q[3:0]}, 32'h0000_0002);
        // quiet line after a frame: timeout after 40 receive clocks
        apb(1'b1, IDX_IDLE_TO, 32'h80);
        tail <= 8'h30;
        @(posedge clk) go <= 1'b1;
        @(posedge clk) go <= 1'b0;
        wait_word(1'b1);
        chk("block end", {21'h0, rx_word}, {21'h0, 3'b101, 8'h00});
        // ss7: one errored unit short of 32, then the 32nd
        apb(1'b1, IDX_MODE, 32'h09);
        apb(1'b1, IDX_CCR3L, 32'h11);
        su_errored <= 1'b1;
        repeat (31) @(posedge clk);
        su_errored <= 1'b0;
        apb(1'b0, IDX_STATUS, 32'h0);
        chk("rate high early", {31'h0, q[0]}, 32'h0);
        su_errored <= 1'b1;
        @(posedge clk);
        su_errored <= 1'b0;
        apb(1'b0, IDX_STATUS, 32'h0);
        chk("rate high", {24'h0, q[14:8], q[0]}, 32'h0000_0041);
        summarize();
    end
endmodule
